// ===== verilog/ead_defines.svh
// Field positions, encodings and limits of the operand address decoder.
`ifndef EAD_DEFINES_SVH
`define EAD_DEFINES_SVH
`define EAD_MAX_WORDS 4'hB
`define EAD_MODE_HI 5
`define EAD_MODE_LO 3
`define EAD_REG_HI 2
`define EAD_REG_LO 0
`define EAD_DMODE_HI 8
`define EAD_DMODE_LO 6
`define EAD_DREG_HI 11
`define EAD_DREG_LO 9
`define EAD_X_TYPE 15
`define EAD_X_REG_HI 14
`define EAD_X_REG_LO 12
`define EAD_X_SIZE 11
`define EAD_X_SCALE_HI 10
`define EAD_X_SCALE_LO 9
`define EAD_X_FULL 8
`define EAD_X_BASE_SUP 7
`define EAD_X_INDEX_SUP 6
`define EAD_X_BD_HI 5
`define EAD_X_BD_LO 4
`define EAD_X_RSVD 3
`define EAD_X_SEL_HI 2
`define EAD_X_SEL_LO 0
`define EAD_MODE_INDEX 3'h6
`define EAD_MODE_DISP 3'h5
`define EAD_MODE_SPECIAL 3'h7
`define EAD_SP_ABS_W 3'h0
`define EAD_SP_ABS_L 3'h1
`define EAD_SP_PC_DISP 3'h2
`define EAD_SP_PC_INDEX 3'h3
`define EAD_SP_IMM 3'h4
`endif

// ===== verilog/ead_pkg.sv
// Types shared by the operand address decoder.
package ead_pkg;
   typedef enum logic [1:0] {LOC_REG_FIELD, LOC_EA, LOC_IMPLICIT} ead_loc_t;
   typedef enum logic [1:0] {IND_NONE, IND_PRE, IND_POST, IND_MEM} ead_ind_t;
   typedef enum logic [2:0] {ST_IDLE, ST_EXT, ST_DISP, ST_DEST} ead_state_t;
   typedef struct packed {
      ead_loc_t loc;
      logic [2:0] imp_reg;
      logic move_dest;
      logic [1:0] imm_words;
   } ead_ctl_t;
   typedef struct packed {
      ead_loc_t loc;
      logic [2:0] mode;
      logic [2:0] reg_num;
      logic prog_space;
      logic has_ext;
      logic full_fmt;
      logic idx_addr;
      logic [2:0] idx_reg;
      logic idx_long;
      logic [3:0] scale_mult;
      logic base_used;
      logic index_used;
      logic [1:0] bd_words;
      logic [1:0] od_words;
      ead_ind_t ind;
      logic [7:0] brief_disp;
      logic reserved;
   } ead_info_t;
endpackage : ead_pkg

// ===== verilog/ead_decoder.sv
// Operand address decoder for the 16-bit instruction word stream.
// Overview of operation
// - An instruction holds one to eleven words; the first word is always present.
// - Mode field picks the mode; register field refines mode 111.
// - Operand located by register field, address field, or implicitly.
// - Indexed modes expect one brief or one full extension word.
// - Extension bit 8 clear means brief with 8-bit displacement; set means full.
// - Index type bit: 0 data register, 1 address register.
// - Index size bit: 0 sign-extended low word, 1 full long word.
// - Full form base suppress 0 adds base register, 1 omits it.
// - Full form index suppress 0 adds index operand, 1 drops it.
// - Base displacement size: 00 reserved, 01 null, 10 word, 11 long.
// - Indirect action comes from selection field together with index suppress.
// - Zero, one or two base displacement words follow a full extension word.
// - Zero, one or two outer displacement words follow the base displacement.
// - Longest move with two full extensions and long displacements is supported.
// - Program-counter-relative operands are program-space references.
// - Index used: 000 none, 001-011 preindexed, 101-111 postindexed, 100 reserved.
// - Index suppressed: 000 none, 001-011 memory indirect, 100-111 reserved.
`timescale 1ns/1ns
`include "ead_defines.svh"
module ead_decoder
   import ead_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Instruction word stream
   input wire logic in_valid,
   input wire logic in_first,
   input wire logic [15:0] in_word,
   input wire ead_ctl_t in_ctl,
   // Decoded operands toward address generation
   output ead_info_t ea_info,
   output logic ea_valid,
   output logic ea_dest,
   output logic instr_done,
   output logic [3:0] instr_words,
   output logic instr_err,
   output logic busy
);
   typedef struct packed {
      ead_state_t st;
      logic [15:0] opw;
      ead_ctl_t ctl;
      logic [3:0] words;
      logic [1:0] skip;
      logic [1:0] od_left;
      logic dest;
      ead_info_t info;
      logic ea_valid;
      logic instr_done;
      logic [3:0] instr_words;
      logic err;
      logic busy;
   } ead_regs_t;

   ead_regs_t q;
   ead_regs_t d;

   // ****************************************************************
   // Next-state decode
   // ****************************************************************
   always_comb
   begin
      logic start;
      logic fin;
      logic [2:0] m;
      logic [2:0] r;
      logic [1:0] sw;
      start = 1'b0;
      fin = 1'b0;
      m = 3'h0;
      r = 3'h0;
      sw = 2'h0;
      d = q;
      d.ea_valid = 1'b0;
      d.instr_done = 1'b0;
      if (in_valid && q.st != ST_IDLE && q.st != ST_DEST)
      begin
         if (q.words == `EAD_MAX_WORDS)
         begin
            d.err = 1'b1;
         end
         else
         begin
            d.words = q.words + 4'h1;
         end
      end
      case (q.st)
         ST_IDLE:
         begin
            if (in_valid && in_first)
            begin
               d.opw = in_word;
               d.ctl = in_ctl;
               d.words = 4'h1;
               d.dest = 1'b0;
               d.err = 1'b0;
               d.info = '0;
               d.info.loc = in_ctl.loc;
               if (in_ctl.loc == LOC_EA)
               begin
                  start = 1'b1;
                  m = in_word[`EAD_MODE_HI:`EAD_MODE_LO];
                  r = in_word[`EAD_REG_HI:`EAD_REG_LO];
               end
               else
               begin
                  // Register-field and implicit operands need no address words.
                  d.info.reg_num = (in_ctl.loc == LOC_REG_FIELD) ?
                     in_word[`EAD_DREG_HI:`EAD_DREG_LO] : in_ctl.imp_reg;
                  fin = 1'b1;
               end
            end
         end
         ST_EXT:
         begin
            if (in_valid)
            begin
               d.info.has_ext = 1'b1;
               d.info.full_fmt = in_word[`EAD_X_FULL];
               d.info.idx_addr = in_word[`EAD_X_TYPE];
               d.info.idx_reg = in_word[`EAD_X_REG_HI:`EAD_X_REG_LO];
               d.info.idx_long = in_word[`EAD_X_SIZE];
               d.info.scale_mult = 4'h1 << in_word[`EAD_X_SCALE_HI:`EAD_X_SCALE_LO];
               if (!in_word[`EAD_X_FULL])
               begin
                  d.info.brief_disp = in_word[7:0];
                  d.info.base_used = 1'b1;
                  d.info.index_used = 1'b1;
                  fin = 1'b1;
               end
               else
               begin
                  d.info.base_used = !in_word[`EAD_X_BASE_SUP];
                  d.info.index_used = !in_word[`EAD_X_INDEX_SUP];
                  case (in_word[`EAD_X_BD_HI:`EAD_X_BD_LO])
                     2'h2: d.info.bd_words = 2'h1;
                     2'h3: d.info.bd_words = 2'h2;
                     default: d.info.bd_words = 2'h0;
                  endcase
                  d.info.od_words = (in_word[1:0] == 2'h3) ? 2'h2 :
                     ((in_word[1:0] == 2'h2) ? 2'h1 : 2'h0);
                  d.info.reserved = (in_word[`EAD_X_BD_HI:`EAD_X_BD_LO] == 2'h0) ||
                     in_word[`EAD_X_RSVD] ||
                     (in_word[2:0] == 3'h4) ||
                     (in_word[`EAD_X_INDEX_SUP] && in_word[2]);
                  if (in_word[2:0] == 3'h0 || in_word[2:0] == 3'h4 ||
                      (in_word[`EAD_X_INDEX_SUP] && in_word[2]))
                  begin
                     d.info.ind = IND_NONE;
                     d.info.od_words = 2'h0;
                  end
                  else if (in_word[`EAD_X_INDEX_SUP])
                  begin
                     d.info.ind = IND_MEM;
                  end
                  else
                  begin
                     d.info.ind = in_word[2] ? IND_POST : IND_PRE;
                  end
                  d.skip = d.info.bd_words;
                  d.od_left = d.info.od_words;
                  if (d.skip != 2'h0)
                  begin
                     d.st = ST_DISP;
                  end
                  else if (d.od_left != 2'h0)
                  begin
                     d.skip = d.od_left;
                     d.od_left = 2'h0;
                     d.st = ST_DISP;
                  end
                  else
                  begin
                     fin = 1'b1;
                  end
               end
            end
         end
         ST_DISP:
         begin
            if (in_valid)
            begin
               d.skip = q.skip - 2'h1;
               if (q.skip == 2'h1)
               begin
                  if (q.od_left != 2'h0)
                  begin
                     d.skip = q.od_left;
                     d.od_left = 2'h0;
                  end
                  else
                  begin
                     fin = 1'b1;
                  end
               end
            end
         end
         ST_DEST:
         begin
            // A move carries a second address field with register and mode swapped.
            // The destination mark rises here so the source pulse is reported as source.
            d.dest = 1'b1;
            d.info = '0;
            d.info.loc = LOC_EA;
            start = 1'b1;
            m = q.opw[`EAD_DMODE_HI:`EAD_DMODE_LO];
            r = q.opw[`EAD_DREG_HI:`EAD_DREG_LO];
         end
         default:
         begin
            d.st = ST_IDLE;
         end
      endcase
      if (start)
      begin
         d.info.mode = m;
         d.info.reg_num = r;
         d.info.prog_space = (m == `EAD_MODE_SPECIAL) &&
            (r == `EAD_SP_PC_DISP || r == `EAD_SP_PC_INDEX);
         if (m == `EAD_MODE_SPECIAL)
         begin
            case (r)
               `EAD_SP_ABS_W: sw = 2'h1;
               `EAD_SP_ABS_L: sw = 2'h2;
               `EAD_SP_PC_DISP: sw = 2'h1;
               `EAD_SP_IMM: sw = d.dest ? 2'h0 : d.ctl.imm_words;
               default: sw = 2'h0;
            endcase
         end
         else
         begin
            sw = (m == `EAD_MODE_DISP) ? 2'h1 : 2'h0;
         end
         if (m == `EAD_MODE_INDEX || (m == `EAD_MODE_SPECIAL && r == `EAD_SP_PC_INDEX))
         begin
            d.st = ST_EXT;
         end
         else if (sw != 2'h0)
         begin
            d.st = ST_DISP;
            d.skip = sw;
            d.od_left = 2'h0;
         end
         else
         begin
            fin = 1'b1;
         end
      end
      if (fin)
      begin
         d.ea_valid = 1'b1;
         if (!d.dest && d.ctl.move_dest)
         begin
            d.st = ST_DEST;
         end
         else
         begin
            d.st = ST_IDLE;
            d.instr_done = 1'b1;
            d.instr_words = d.words;
         end
      end
      d.busy = (d.st != ST_IDLE);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign ea_info = q.info;
   assign ea_valid = q.ea_valid;
   assign ea_dest = q.dest;
   assign instr_done = q.instr_done;
   assign instr_words = q.instr_words;
   assign instr_err = q.err;
   assign busy = q.busy;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_word_count_max: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.instr_done && !q.err |-> q.instr_words >= 4'h1 && q.instr_words <= 4'hB)
      else $error("Instruction length outside one to eleven words.");
   a_mode_reg_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.ea_valid && !q.dest && q.info.loc == LOC_EA |->
      q.info.mode == q.opw[5:3] && q.info.reg_num == q.opw[2:0])
      else $error("Source mode or register not taken from the operation word.");
   a_reg_field_loc: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.ea_valid && q.info.loc == LOC_REG_FIELD |-> q.info.reg_num == q.opw[11:9])
      else $error("Register-field operand has the wrong register.");
   a_ext_expected: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.st == ST_EXT |-> q.info.mode == 3'h6 || (q.info.mode == 3'h7 && q.info.reg_num == 3'h3))
      else $error("Extension word expected for a non-indexed mode.");
   a_ext_fields: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.st == ST_EXT && in_valid |=> q.info.full_fmt == $past(in_word[8]) &&
      q.info.idx_addr == $past(in_word[15]) && q.info.idx_long == $past(in_word[11]))
      else $error("Extension format, index type or size misdecoded.");
   a_suppress_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.st == ST_EXT && in_valid && in_word[8] |=>
      q.info.base_used == !$past(in_word[7]) && q.info.index_used == !$past(in_word[6]))
      else $error("Base or index suppress misdecoded.");
   a_base_disp_size: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.st == ST_EXT && in_valid && in_word[8] && in_word[5:4] == 2'h3 |=> q.info.bd_words == 2'h2)
      else $error("Long base displacement not two words.");
   a_scale_map: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.st == ST_EXT && in_valid |=> q.info.scale_mult == (4'h1 << $past(in_word[10:9])))
      else $error("Scale multiplier wrong.");
   a_prog_space: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.ea_valid && q.info.loc == LOC_EA && q.info.mode == 3'h7 && q.info.reg_num[2:1] == 2'h1
      |-> q.info.prog_space)
      else $error("Program-counter-relative operand not marked as program space.");
   a_post_map: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.st == ST_EXT && in_valid && in_word[8] && !in_word[6] && in_word[2] && in_word[1:0] != 2'h0
      |=> q.info.ind == IND_POST)
      else $error("Postindexed selection misdecoded.");
   a_disp_words: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.st == ST_EXT && in_valid && in_word[8] && !in_word[6] && in_word[5:4] == 2'h3 &&
      in_word[2:0] == 3'h3 && !in_word[3] |=> q.st == ST_DISP && q.skip == 2'h2 && q.od_left == 2'h2)
      else $error("Displacement word counts wrong after a full extension.");
endmodule : ead_decoder

// ===== verif/ead_stream_src.sv
// Instruction word source that feeds the decoder one word per cycle.
`timescale 1ns/1ns
module ead_stream_src
(
   // Clock
   input wire logic core_clk,
   // Stream toward the decoder
   output logic in_valid,
   output logic in_first,
   output logic [15:0] in_word
);
   initial
   begin
      in_valid = 1'b0;
      in_first = 1'b0;
      in_word = 16'h0000;
   end
   // An idle cycle comes before word pa, and gap idle cycles before each later word.
   // Each idle cycle inverts the word lines, so a single idle cycle shows the inverse of the last word.
   task automatic send(input logic [15:0] w [11], input int n, input int pa, input int gap);
      int k;
      for (int i = 0; i < n && i < 11; i++)
      begin
         k = (i == pa) ? 1 : ((i > 0) ? gap : 0);
         repeat (k)
         begin
            @(negedge core_clk);
            in_valid = 1'b0;
            in_word = ~in_word;
         end
         @(negedge core_clk);
         in_valid = 1'b1;
         in_first = (i == 0);
         in_word = w[i];
      end
      @(negedge core_clk);
      in_valid = 1'b0;
      in_first = 1'b0;
      in_word = ~in_word;
   endtask : send
endmodule : ead_stream_src

// ===== verif/ea_extension_word_decoder_tb.sv
// Self-checking bench for the operand address decoder.
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
   begin \
      num_checks++; \
      if ((got) !== (ex)) \
      begin \
         $display("[ERR] %s expected %h seen %h", nm, ex, got); \
         n_mismatch++; \
      end \
   end
module ea_extension_word_decoder_tb
   import ead_pkg::*;
;
   logic core_clk, rst_n, in_valid, in_first, ea_valid, ea_dest, instr_done, instr_err, busy;
   logic [15:0] in_word;
   logic [3:0] instr_words, words_q;
   ead_ctl_t in_ctl;
   ead_info_t ea_info, src_i, dst_i;
   logic [15:0] wq [11];
   int n_mismatch = 0, num_checks = 0, n_ea = 0, n_done = 0, cyc = 0;
   ead_decoder i_dut (.core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid),
      .in_first(in_first), .in_word(in_word), .in_ctl(in_ctl), .ea_info(ea_info),
      .ea_valid(ea_valid), .ea_dest(ea_dest), .instr_done(instr_done),
      .instr_words(instr_words), .instr_err(instr_err), .busy(busy));
   ead_stream_src i_src (.core_clk(core_clk), .in_valid(in_valid), .in_first(in_first),
      .in_word(in_word));
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   always @(negedge core_clk)
   begin
      if (ea_valid === 1'b1)
      begin
         n_ea++;
         if (ea_dest === 1'b1)
            dst_i = ea_info;
         else
            src_i = ea_info;
      end
      if (instr_done === 1'b1)
      begin
         n_done++;
         words_q = instr_words;
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic run(input int n, input int pa, input int gap, input logic [3:0] ew,
      input int ee);
      int d0;
      int t;
      d0 = n_done;
      n_ea = 0;
      i_src.send(wq, n, pa, gap);
      t = 0;
      while (n_done == d0 && t < 20)
      begin
         @(negedge core_clk);
         t++;
      end
      `CHK("done", d0 + 1, n_done)
      `CHK("instr_words", ew, words_q)
      `CHK("operands", ee, n_ea)
   endtask : run
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_locate();
      wq = '{default: 16'hA4C3};
      in_ctl = '{loc: LOC_EA, imp_reg: 3'h0, move_dest: 1'b0, imm_words: 2'h2};
      wq[0] = 16'h0003;
      run(1, -1, 0, 4'h1, 1);
      `CHK("loc_ea", LOC_EA, src_i.loc)
      `CHK("reg_ea", 3'h3, src_i.reg_num)
      in_ctl.loc = LOC_REG_FIELD;
      wq[0] = 16'h0A00;
      run(1, -1, 0, 4'h1, 1);
      `CHK("loc_reg", LOC_REG_FIELD, src_i.loc)
      `CHK("reg_fld", 3'h5, src_i.reg_num)
      in_ctl.loc = LOC_IMPLICIT;
      in_ctl.imp_reg = 3'h6;
      run(1, -1, 0, 4'h1, 1);
      `CHK("reg_imp", 3'h6, src_i.reg_num)
      in_ctl.loc = LOC_EA;
   endtask : t_locate
   task automatic t_special();
      for (int r = 0; r < 5; r++)
      begin
         wq[0] = 16'h0038 | 16'(r);
         run((r == 1 || r == 4) ? 3 : 2, -1, 0, (r == 1 || r == 4) ? 4'h3 : 4'h2, 1);
         `CHK("mode7", 3'h7, src_i.mode)
         `CHK("sel7", 3'(r), src_i.reg_num)
         `CHK("prog", (r == 2 || r == 3), src_i.prog_space)
      end
   endtask : t_special
   task automatic t_brief();
      for (int k = 0; k < 2; k++)
      begin
         wq[0] = 16'h0031;
         wq[1] = (k == 0) ? 16'hDC5A : 16'h2000;
         run(2, -1, 0, 4'h2, 1);
         `CHK("full_b", 1'b0, src_i.full_fmt)
         `CHK("ext_b", 1'b1, src_i.has_ext)
         `CHK("disp_b", wq[1][7:0], src_i.brief_disp)
         `CHK("xtype", (k == 0), src_i.idx_addr)
         `CHK("xreg", (k == 0) ? 3'h5 : 3'h2, src_i.idx_reg)
         `CHK("xlong", (k == 0), src_i.idx_long)
         `CHK("scale_b", (k == 0) ? 4'h4 : 4'h1, src_i.scale_mult)
      end
   endtask : t_brief
   task automatic t_full();
      logic rsv;
      ead_ind_t ind;
      int od;
      for (int is = 0; is < 2; is++)
         for (int bd = 1; bd < 4; bd++)
            for (int sel = 0; sel < 8; sel++)
            begin
               wq[0] = 16'h0032;
               wq[1] = {is[0], 3'h2, sel[0], sel[1:0], 1'b1, sel[0], is[0], bd[1:0], 1'b0,
                  sel[2:0]};
               rsv = (is == 0 && sel == 4) || (is == 1 && sel >= 4);
               ind = (rsv || sel == 0) ? IND_NONE : (is == 1) ? IND_MEM :
                  (sel < 4) ? IND_PRE : IND_POST;
               od = rsv ? 0 : (sel[1:0] == 2'h3) ? 2 : (sel[1:0] == 2'h2) ? 1 : 0;
               run(1 + bd + od, -1, (sel == 7) ? 1 : 0, 4'(1 + bd + od), 1);
               `CHK("full_f", 1'b1, src_i.full_fmt)
               `CHK("base", ~sel[0], src_i.base_used)
               `CHK("index", ~is[0], src_i.index_used)
               `CHK("bd_w", 2'(bd - 1), src_i.bd_words)
               `CHK("od_w", 2'(od), src_i.od_words)
               `CHK("ind", ind, src_i.ind)
               `CHK("rsv", rsv, src_i.reserved)
               `CHK("xtype_f", is[0], src_i.idx_addr)
               `CHK("scale_f", 4'h1 << sel[1:0], src_i.scale_mult)
            end
   endtask : t_full
   task automatic t_move();
      in_ctl.move_dest = 1'b1;
      wq = '{default: 16'hA4C3};
      wq[0] = 16'h09B5;
      wq[1] = 16'h0133;
      wq[6] = 16'h0133;
      run(11, 6, 0, 4'hB, 2);
      `CHK("src_reg", 3'h5, src_i.reg_num)
      `CHK("src_od", 2'h2, src_i.od_words)
      `CHK("dst_reg", 3'h4, dst_i.reg_num)
      `CHK("dst_mode", 3'h6, dst_i.mode)
      `CHK("dst_od", 2'h2, dst_i.od_words)
      `CHK("dst_bd", 2'h2, dst_i.bd_words)
      `CHK("err", 1'b0, instr_err)
      in_ctl.move_dest = 1'b0;
   endtask : t_move
   initial
   begin
      rst_n = 1'b0;
      in_ctl = '0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      `CHK("rst_busy", 1'b0, busy)
      `CHK("rst_words", 4'h0, instr_words)
      `CHK("rst_info", '0, ea_info)
      t_locate();
      t_special();
      t_brief();
      t_full();
      t_move();
      final_report();
   end
endmodule : ea_extension_word_decoder_tb
